// >>> rtl/eltr_pkg.sv
// Constants for the calibration memory lock, signature and trim restore.
package eltr_pkg;

    // ------------------------------------------------------------------
    // Memory layout
    // ------------------------------------------------------------------
    localparam int EE_BITS = 152;
    localparam int EE_BYTES = 19;
    localparam int LOCK_LSB = 103;
    localparam int LOCK_W = 3;
    localparam logic [2:0] LOCK_CODE_A = 3'h6;
    localparam logic [2:0] LOCK_CODE_B = 3'h3;
    localparam int SIG_LSB = 144;
    localparam int TRIM_LSB = 3;
    localparam int TRIM_W = 4;
    localparam int BACKUP_HI_LSB = 124;
    localparam int BACKUP_LO_LSB = 120;
    localparam int OSEL_LSB = 11;
    localparam int DUMP_ROT = 32;
    localparam logic [151:0] EE_RESET = 152'h0;

    // ------------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------------
    localparam logic [15:0] CMD_READ = 16'h0000;
    localparam logic [15:0] CMD_UNLOCK = 16'hE800;

    // ------------------------------------------------------------------
    // Register byte addresses and fields
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CMD = 12'h004;
    localparam logic [11:0] ADDR_WRITE = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;
    localparam int CTRL_CMD_MODE = 0;
    localparam int CTRL_DIGITAL = 1;
    localparam int WR_IDX_LSB = 0;
    localparam int WR_DATA_LSB = 8;

    // ------------------------------------------------------------------
    // Engine states
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_SIGN = 3'b010,
        ST_DUMP = 3'b100
    } eltr_state_t;

endpackage

// >>> rtl/eltr_signature.sv
// CRC-8 signature over the memory contents below the signature byte.
module eltr_signature (
    input wire logic [143:0] data,
    output logic [7:0] sig
);

    // ------------------------------------------------------------------
    // Bitwise CRC, polynomial x^8+x^2+x+1, walked from the top bit down.
    // ------------------------------------------------------------------
    // This CRC catches all single flips and double flips under 127 bits apart, which is the sawing hazard.
    always_comb
    begin
        logic fb;
        fb = 1'b0;
        sig = 8'hFF;
        for (int i = 143; i >= 0; i--)
        begin
            fb = sig[7] ^ data[i];
            sig = {sig[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
        end
    end

endmodule

// >>> rtl/eltr_top.sv
// Calibration memory with lock, force-unlock, signature and trim copies.
//
// Added by the designer: the APB interface to the registers and the register offsets.
module eltr_top #(
    parameter int DATA_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic meas_valid,
    input wire logic [DATA_W-1:0] bridge_value,
    input wire logic [DATA_W-1:0] temp_value,
    output logic tx_valid,
    output logic tx_is_temp,
    output logic [DATA_W-1:0] tx_data,
    output logic dump_valid,
    output logic [7:0] dump_byte,
    input wire logic dump_ready,
    output logic charge_pump_en,
    output logic [3:0] reference_trim_field
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (DATA_W < 1 || DATA_W > 32)
    begin : g_bad_width
        $error("DATA_W must lie between 1 and 32.");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [151:0] image;
    logic [151:0] next_image;
    logic [151:0] shreg;
    logic [151:0] next_shreg;
    eltr_pkg::eltr_state_t state;
    eltr_pkg::eltr_state_t next_state;
    logic [4:0] dump_cnt;
    logic [4:0] next_dump_cnt;
    logic force_unlock;
    logic next_force_unlock;
    logic cmd_mode;
    logic next_cmd_mode;
    logic digital_mode;
    logic next_digital_mode;
    logic temp_pending;
    logic next_temp_pending;
    logic [DATA_W-1:0] temp_hold;
    logic [DATA_W-1:0] next_temp_hold;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_tx_valid;
    logic next_tx_is_temp;
    logic [DATA_W-1:0] next_tx_data;
    logic next_dump_valid;
    logic [7:0] next_dump_byte;
    logic next_pump;

    logic [7:0] sig_calc;
    logic [2:0] lock_field;
    logic locked;
    logic pump_ok;
    logic acc;
    logic wr_cmd;
    logic wr_ee;
    logic ee_ok;
    logic [4:0] wr_idx;
    logic [7:0] wr_byte;
    logic [3:0] trim;
    logic [3:0] bk_hi;
    logic [3:0] bk_lo;
    logic [2:0] agree;

    eltr_signature u_sig (
        .data(image[143:0]),
        .sig(sig_calc)
    );

    // ------------------------------------------------------------------
    // Lock decode and write permission
    // ------------------------------------------------------------------
    // Only the two locking codes stop the pump; the force flag overrides.
    assign lock_field = image[eltr_pkg::LOCK_LSB +: eltr_pkg::LOCK_W];
    assign locked = (lock_field == eltr_pkg::LOCK_CODE_A) ||
                    (lock_field == eltr_pkg::LOCK_CODE_B);
    assign pump_ok = force_unlock || !locked;

    // Trim field and its two backups, compared for the restore procedure.
    assign trim = image[eltr_pkg::TRIM_LSB +: eltr_pkg::TRIM_W];
    assign bk_hi = image[eltr_pkg::BACKUP_HI_LSB +: eltr_pkg::TRIM_W];
    assign bk_lo = image[eltr_pkg::BACKUP_LO_LSB +: eltr_pkg::TRIM_W];
    assign agree = {trim == bk_lo, bk_hi == bk_lo, trim == bk_hi};

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // One wait state: pready rises the cycle after the access phase.
    assign acc = psel && penable && !pready;
    assign wr_cmd = acc && pwrite && (paddr == eltr_pkg::ADDR_CMD) && cmd_mode;
    assign wr_idx = pwdata[eltr_pkg::WR_IDX_LSB +: 5];
    assign wr_byte = pwdata[eltr_pkg::WR_DATA_LSB +: 8];
    assign ee_ok = cmd_mode && pump_ok && (state == eltr_pkg::ST_IDLE) &&
                   (wr_idx < 5'(eltr_pkg::EE_BYTES));
    assign wr_ee = acc && pwrite && (paddr == eltr_pkg::ADDR_WRITE) && ee_ok;

    // ------------------------------------------------------------------
    // Bus slave next values
    // ------------------------------------------------------------------
    // Refused memory writes and unmapped addresses answer with pslverr.
    always_comb
    begin
        next_pready = acc;
        next_prdata = 32'h0;
        next_pslverr = 1'b0;
        next_cmd_mode = cmd_mode;
        next_digital_mode = digital_mode;
        if (acc)
        begin
            unique case (paddr)
                eltr_pkg::ADDR_CTRL:
                begin
                    if (pwrite)
                    begin
                        next_cmd_mode = pwdata[eltr_pkg::CTRL_CMD_MODE];
                        next_digital_mode = pwdata[eltr_pkg::CTRL_DIGITAL];
                    end
                    next_prdata = {30'h0, digital_mode, cmd_mode};
                end
                eltr_pkg::ADDR_CMD:
                begin
                    next_pslverr = pwrite && !cmd_mode;
                end
                eltr_pkg::ADDR_WRITE:
                begin
                    next_pslverr = pwrite && !ee_ok;
                end
                eltr_pkg::ADDR_STATUS:
                begin
                    next_prdata = {12'h0, trim, image[eltr_pkg::SIG_LSB +: 8],
                                   agree, state == eltr_pkg::ST_DUMP,
                                   state != eltr_pkg::ST_IDLE, pump_ok,
                                   force_unlock, locked};
                end
                default:
                begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
            cmd_mode <= 1'b0;
            digital_mode <= 1'b0;
        end
        else
        begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            cmd_mode <= next_cmd_mode;
            digital_mode <= next_digital_mode;
        end
    end

    // ------------------------------------------------------------------
    // Memory engine next values
    // ------------------------------------------------------------------
    // The signature is stored one cycle after a write, from the new image.
    always_comb
    begin
        next_image = image;
        next_state = state;
        next_shreg = shreg;
        next_dump_cnt = dump_cnt;
        next_force_unlock = force_unlock;
        next_dump_valid = dump_valid;
        next_dump_byte = dump_byte;
        if (wr_cmd && pwdata[15:0] == eltr_pkg::CMD_UNLOCK)
        begin
            next_force_unlock = 1'b1;
        end
        unique case (state)
            eltr_pkg::ST_IDLE:
            begin
                if (wr_ee)
                begin
                    // Any byte, the lock byte included, while pumping.
                    next_image[8*wr_idx +: 8] = wr_byte;
                    next_state = eltr_pkg::ST_SIGN;
                end
                else if (wr_cmd && pwdata[15:0] == eltr_pkg::CMD_READ)
                begin
                    // Start at the byte holding bits 39:32, wrap to 31:24.
                    next_shreg = {image[eltr_pkg::DUMP_ROT-1:0],
                                  image[151:eltr_pkg::DUMP_ROT]};
                    next_dump_cnt = 5'h0;
                    next_dump_valid = 1'b1;
                    next_dump_byte = image[eltr_pkg::DUMP_ROT +: 8];
                    next_state = eltr_pkg::ST_DUMP;
                end
            end
            eltr_pkg::ST_SIGN:
            begin
                next_image[eltr_pkg::SIG_LSB +: 8] = sig_calc;
                next_state = eltr_pkg::ST_IDLE;
            end
            eltr_pkg::ST_DUMP:
            begin
                if (dump_ready)
                begin
                    // Rotate eight bits per byte sent.
                    next_shreg = {shreg[7:0], shreg[151:8]};
                    next_dump_byte = shreg[15:8];
                    next_dump_cnt = dump_cnt + 5'h1;
                    if (dump_cnt == 5'(eltr_pkg::EE_BYTES - 1))
                    begin
                        next_dump_valid = 1'b0;
                        next_state = eltr_pkg::ST_IDLE;
                    end
                end
            end
        endcase
        next_pump = next_force_unlock ||
                    !((next_image[eltr_pkg::LOCK_LSB +: 3] ==
                       eltr_pkg::LOCK_CODE_A) ||
                      (next_image[eltr_pkg::LOCK_LSB +: 3] ==
                       eltr_pkg::LOCK_CODE_B));
    end

    // Reset reloads the default image, standing in for a nonvolatile load.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            image <= eltr_pkg::EE_RESET;
            shreg <= 152'h0;
            state <= eltr_pkg::ST_IDLE;
            dump_cnt <= 5'h0;
            force_unlock <= 1'b0;
            dump_valid <= 1'b0;
            dump_byte <= 8'h0;
            charge_pump_en <= 1'b0;
            reference_trim_field <= 4'h0;
        end
        else
        begin
            image <= next_image;
            shreg <= next_shreg;
            state <= next_state;
            dump_cnt <= next_dump_cnt;
            force_unlock <= next_force_unlock;
            dump_valid <= next_dump_valid;
            dump_byte <= next_dump_byte;
            charge_pump_en <= next_pump;
            reference_trim_field <= next_image[eltr_pkg::TRIM_LSB +: 4];
        end
    end

    // ------------------------------------------------------------------
    // Digital output transmissions
    // ------------------------------------------------------------------
    // Output select zero sends bridge only; else temperature follows next.
    always_comb
    begin
        next_tx_valid = 1'b0;
        next_tx_is_temp = 1'b0;
        next_tx_data = tx_data;
        next_temp_pending = 1'b0;
        next_temp_hold = temp_hold;
        if (temp_pending)
        begin
            next_tx_valid = 1'b1;
            next_tx_is_temp = 1'b1;
            next_tx_data = temp_hold;
        end
        else if (meas_valid && digital_mode)
        begin
            next_tx_valid = 1'b1;
            next_tx_data = bridge_value;
            next_temp_hold = temp_value;
            next_temp_pending =
                image[eltr_pkg::OSEL_LSB +: 2] != 2'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_valid <= 1'b0;
            tx_is_temp <= 1'b0;
            tx_data <= '0;
            temp_pending <= 1'b0;
            temp_hold <= '0;
        end
        else
        begin
            tx_valid <= next_tx_valid;
            tx_is_temp <= next_tx_is_temp;
            tx_data <= next_tx_data;
            temp_pending <= next_temp_pending;
            temp_hold <= next_temp_hold;
        end
    end

endmodule

// >>> testbench/eltr_monitor.sv
// Port-level concurrent checks for the calibration memory block.
module eltr_monitor #(
    parameter int DATA_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic meas_valid,
    input wire logic [DATA_W-1:0] bridge_value,
    input wire logic [DATA_W-1:0] temp_value,
    input wire logic tx_valid,
    input wire logic tx_is_temp,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic dump_valid,
    input wire logic [7:0] dump_byte,
    input wire logic dump_ready,
    input wire logic charge_pump_en,
    input wire logic [3:0] reference_trim_field
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [4:0] hs_cnt;
    logic unl_seen;
    logic take_wr;

    // A memory write is taken at the edge that ends the wait state.
    assign take_wr = psel && penable && !pready && pwrite
        && paddr == eltr_pkg::ADDR_WRITE;

    // Count stream handshakes and remember an accepted force-unlock.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hs_cnt <= 5'h00;
            unl_seen <= 1'b0;
        end
        else
        begin
            hs_cnt <= dump_valid ? hs_cnt + {4'h0, dump_ready} : 5'h00;
            if (pready && psel && pwrite && !pslverr
                && paddr == eltr_pkg::ADDR_CMD
                && pwdata[15:0] == eltr_pkg::CMD_UNLOCK)
                unl_seen <= 1'b1;
        end
    end

    a_access_answer: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    a_unmapped_error: assert property (pready && paddr[11:4] != 8'h00 |->
        pslverr && prdata == 32'h0)
        else $error("unmapped access not flagged");
    a_locked_refused: assert property (pready && pwrite
        && paddr == eltr_pkg::ADDR_WRITE && !$past(charge_pump_en) |-> pslverr)
        else $error("memory write accepted with the pump off");
    a_unlock_holds: assert property (unl_seen |=> charge_pump_en)
        else $error("pump off after a force-unlock");
    a_dump_hold: assert property (dump_valid && !dump_ready |=>
        dump_valid && $stable(dump_byte))
        else $error("stream byte moved without a handshake");
    a_dump_length: assert property ($fell(dump_valid) |->
        hs_cnt == 5'h13)
        else $error("stream ended after a wrong byte count");
    a_bridge_word: assert property (tx_valid && !tx_is_temp |->
        $past(meas_valid) && tx_data == $past(bridge_value))
        else $error("bridge word not from the last measurement");
    a_temp_word: assert property (tx_valid && tx_is_temp |->
        $past(tx_valid) && !$past(tx_is_temp)
        && tx_data == $past(temp_value, 2))
        else $error("temperature word out of place");
    a_trim_by_write: assert property ($changed(reference_trim_field) |->
        $past(take_wr) || $past(take_wr, 2))
        else $error("trim output moved without a memory write");
endmodule

bind eltr_top eltr_monitor #(.DATA_W(DATA_W)) i_monitor (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_valid(meas_valid),
    .bridge_value(bridge_value), .temp_value(temp_value),
    .tx_valid(tx_valid), .tx_is_temp(tx_is_temp), .tx_data(tx_data),
    .dump_valid(dump_valid), .dump_byte(dump_byte),
    .dump_ready(dump_ready), .charge_pump_en(charge_pump_en),
    .reference_trim_field(reference_trim_field)
);

// >>> testbench/eltr_host_model.sv
// Calibration host model that consumes the memory read stream.
module eltr_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic dump_valid,
    input wire logic [7:0] dump_byte,
    output logic dump_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got [0:18];
    int seen;

    // Every stream is 19 bytes, so the index wraps back for the next one.
    always @(posedge clk)
    begin
        if (rst)
        begin
            seen <= 0;
            dump_ready <= 1'b0;
        end
        else
        begin
            if (dump_valid && dump_ready)
            begin
                got[seen % 19] <= dump_byte;
                seen <= seen + 1;
            end
            dump_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
        end
    end
endmodule

// >>> testbench/tb_eltr_top.sv
// Self-checking bench for the calibration memory block.
`define CHK(a, e) \
    begin \
        comparisons++; \
        if ((a) !== (e)) \
        begin \
            errors++; \
            $display("CHECK FAILED at %0t got %h exp %h", $time, a, e); \
        end \
    end

module tb_eltr_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] DEF_BYTE = 8'h00;
    localparam logic [3:0] NEW_TRIM = 4'h8;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, meas_valid, slow;
    logic tx_valid, tx_is_temp, dump_valid, dump_ready, charge_pump_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [15:0] bridge_value, temp_value, tx_data;
    logic [7:0] dump_byte;
    logic [3:0] reference_trim_field;
    logic [151:0] img;
    logic rerr, cm, unl;
    int errors, comparisons;

    eltr_top #(.DATA_W(16)) i_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas_valid(meas_valid),
        .bridge_value(bridge_value), .temp_value(temp_value),
        .tx_valid(tx_valid), .tx_is_temp(tx_is_temp), .tx_data(tx_data),
        .dump_valid(dump_valid), .dump_byte(dump_byte),
        .dump_ready(dump_ready), .charge_pump_en(charge_pump_en),
        .reference_trim_field(reference_trim_field)
    );
    eltr_host_model i_host (
        .clk(clk), .rst(rst), .slow(slow), .dump_valid(dump_valid),
        .dump_byte(dump_byte), .dump_ready(dump_ready)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic lk(input logic [151:0] m);
        return m[105:103] == 3'h6 || m[105:103] == 3'h3;
    endfunction

    // Signature over bits 143..0, most significant bit first.
    function automatic logic [7:0] crc8(input logic [151:0] m);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 143; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    // Keep a trim that matches a copy, else take agreeing copies.
    function automatic logic [3:0] vote(input logic [3:0] t, hi, lo);
        if (t == hi || t == lo)
            return t;
        return (hi == lo) ? hi : NEW_TRIM;
    endfunction

    // One bus transfer; the request holds until ready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready.
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr_byte(input logic [4:0] k, input logic [7:0] v);
        logic ok;
        ok = cm && k < 5'h13 && (unl || !lk(img));
        apb(1'b1, eltr_pkg::ADDR_WRITE, {16'h0000, v, 3'h0, k});
        `CHK(rerr, !ok)
        if (ok)
        begin
            img[8 * k +: 8] = v;
            img[151:144] = crc8(img);
        end
        `CHK(charge_pump_en, unl || !lk(img))
    endtask

    task automatic chk_st();
        logic [3:0] t, hi, lo;
        logic [19:0] st;
        t = img[6:3];
        hi = img[127:124];
        lo = img[123:120];
        apb(1'b0, eltr_pkg::ADDR_STATUS, 32'h0);
        st = {t, img[151:144], t == lo, hi == lo, t == hi, 2'b00,
            unl || !lk(img), unl, lk(img)};
        `CHK(rdata, {12'h000, st})
        `CHK(reference_trim_field, t)
    endtask

    task automatic set_ctrl(input logic [1:0] v);
        apb(1'b1, eltr_pkg::ADDR_CTRL, {30'h0, v});
        cm = v[0];
        `CHK(rerr, 1'b0)
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        img = '0;
        cm = 1'b0;
        unl = 1'b0;
        repeat (3) @(posedge clk);
        `CHK({charge_pump_en, dump_valid, tx_valid}, 3'h4)
    endtask

    // The stream starts at byte 4 and wraps round to byte 3.
    task automatic run_dump();
        int base, n;
        slow <= 1'($urandom_range(1));
        base = i_host.seen;
        apb(1'b1, eltr_pkg::ADDR_CMD, 32'h0);
        n = 0;
        while (dump_valid === 1'b1 && ++n < 400)
            @(posedge clk);
        `CHK(i_host.seen - base, 19)
        for (int k = 0; k < 19; k++)
            `CHK(i_host.got[k], img[8 * ((k + 4) % 19) +: 8])
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    // Trim cases: stored trim, high copy, low copy, expected result.
    initial
    begin
        logic [15:0] cs [4];
        logic [7:0] b0, b15;
        logic [15:0] br, tp;
        cs = '{16'h55A5, 16'h3C33, 16'h9EEE, 16'h1248};
        {psel, penable, pwrite, meas_valid, slow} = '0;
        rst = 1'b1;
        paddr = '0;
        pwdata = '0;
        bridge_value = '0;
        temp_value = '0;
        errors = 0;
        comparisons = 0;
        void'($urandom(32'hB1B7CBE4));
        do_reset();
        wr_byte(5'h00, 8'hA5);
        apb(1'b1, eltr_pkg::ADDR_CMD, {16'h0000, eltr_pkg::CMD_UNLOCK});
        `CHK(rerr, 1'b1)
        apb(1'b0, 12'h010, 32'h0);
        `CHK(rerr, 1'b1)
        `CHK(rdata, 32'h0)
        set_ctrl(2'h1);
        wr_byte(5'h13, 8'h3C);
        repeat (16) wr_byte(5'($urandom_range(18)), 8'($urandom));
        chk_st();
        // Walk all eight lock codes, then escape with the force-unlock.
        for (int v = 0; v < 8; v++)
        begin
            do_reset();
            set_ctrl(2'h1);
            wr_byte(5'h0C, {v[0], 7'($urandom)});
            wr_byte(5'h0D, {6'($urandom), v[2:1]});
            wr_byte(5'h02, 8'($urandom));
            apb(1'b1, eltr_pkg::ADDR_CMD, {16'h0000, eltr_pkg::CMD_UNLOCK});
            unl = 1'b1;
            `CHK(rerr, 1'b0)
            `CHK(charge_pump_en, 1'b1)
            wr_byte(5'h0D, 8'h00);
            chk_st();
        end
        // Restore the trim from the streamed image, then refresh defaults.
        for (int c = 0; c < 4; c++)
        begin
            wr_byte(5'h00, {img[7], cs[c][15:12], img[2:0]});
            wr_byte(5'h0F, cs[c][11:4]);
            run_dump();
            b0 = i_host.got[15];
            b15 = i_host.got[11];
            b0[6:3] = vote(b0[6:3], b15[7:4], b15[3:0]);
            wr_byte(5'h00, {DEF_BYTE[7], b0[6:0]});
            for (int k = 1; k < 18; k++)
                wr_byte(5'(k), DEF_BYTE);
            `CHK(reference_trim_field, cs[c][3:0])
            chk_st();
        end
        // Each output select value: bridge alone or bridge then temperature.
        set_ctrl(2'h3);
        for (int o = 0; o < 4; o++)
        begin
            wr_byte(5'h01, {img[15:13], 2'(o), img[10:8]});
            repeat (3)
            begin
                br = 16'($urandom);
                tp = 16'($urandom);
                meas_valid <= 1'b1;
                bridge_value <= br;
                temp_value <= tp;
                @(posedge clk);
                meas_valid <= 1'b0;
                // The bridge word stands in the cycle after the sample edge.
                @(posedge clk);
                `CHK(tx_valid & !tx_is_temp, 1'b1)
                `CHK(tx_data, br)
                @(posedge clk);
                `CHK(tx_valid, o != 0)
                if (o != 0)
                    `CHK(tx_data, tp)
            end
        end
        report_and_stop();
    end
endmodule
